// file: rtl/pma_core.sv
// Parallel multiply-subtract, halfword multiply and accumulator moves.
// Assumes the decoder presents operands and op in the cycle of op_valid
// and takes the destination result when dest_we_q pulses.
`timescale 1ns/1ns
`default_nettype none
`include "pma_params.svh"

// Functional notes
// - Word msub uses low words of doublewords
// - Subtract product from upper:lower accumulator pair
// - Difference to dest; halves sign-extended to accumulators
// - No arithmetic exceptions; results wrap
// - Upper move copies whole register, lower kept
// - Lower move copies whole register, upper kept
// - Interleaved move: even/odd words split, rest kept
// - Eight signed halfword products in parallel
// - Halfword products fill accumulators in pairs, alternating lower and upper
module pma_core (
   input  wire logic                   core_clk,
   input  wire logic                   rstn,
   input  wire logic                   op_valid,
   input  wire logic [`PMA_OP_W-1:0]   op_code,
   input  wire logic [`PMA_FMT_W-1:0]  fmt,
   input  wire logic [`PMA_REG_W-1:0]  first_source,
   input  wire logic [`PMA_REG_W-1:0]  second_source,
   output logic      [`PMA_REG_W-1:0]  dest_q,
   output logic                        dest_we_q,
   output logic                        done_q,
   output logic      [`PMA_REG_W-1:0]  upper_acc_q,
   output logic      [`PMA_REG_W-1:0]  lower_acc_q
);

   // Registered state and its next value
   pma_pkg::pma_state_type state_q;  // All flops of this block
   pma_pkg::pma_state_type state_d;  // Next state from the datapath

   // Halfword products, eight words packed low lane first
   logic [`PMA_NHALF*`PMA_WORD_W-1:0] half_prod;
   // Decoded operation
   pma_pkg::pma_op_type               op;

   assign op = pma_pkg::pma_op_type'(op_code);

   // Word lane extraction, used for sources and accumulators
   function automatic logic [`PMA_WORD_W-1:0] word_of(
      input logic [`PMA_REG_W-1:0] v,
      input int                    idx
   );
      word_of = v[idx*`PMA_WORD_W +: `PMA_WORD_W];
   endfunction

   // Product word from the packed halfword product vector
   function automatic logic [`PMA_WORD_W-1:0] prod_of(
      input logic [`PMA_NHALF*`PMA_WORD_W-1:0] v,
      input int                                idx
   );
      prod_of = v[idx*`PMA_WORD_W +: `PMA_WORD_W];
   endfunction

   // Signed word multiply-subtract on one doubleword lane.
   // The difference is cut to 64 bits on purpose: wrap, never trap.
   function automatic logic [`PMA_DWORD_W-1:0] msub_lane(
      input logic [`PMA_WORD_W-1:0] acc_hi,
      input logic [`PMA_WORD_W-1:0] acc_lo,
      input logic [`PMA_WORD_W-1:0] a,
      input logic [`PMA_WORD_W-1:0] b
   );
      logic signed [`PMA_DWORD_W-1:0] prod;  // Full signed product
      logic        [`PMA_DWORD_W-1:0] acc;   // Upper:lower accumulator pair
      // Doubleword target widens both signed words before the multiply
      prod = $signed(a) * $signed(b);
      acc  = {acc_hi, acc_lo};
      msub_lane = `PMA_DWORD_W'(acc - prod);
   endfunction

   // Sign-extend one word to a doubleword
   function automatic logic [`PMA_DWORD_W-1:0] sext_word(
      input logic [`PMA_WORD_W-1:0] w
   );
      sext_word = {{`PMA_WORD_W{w[`PMA_WORD_W-1]}}, w};
   endfunction

   // Halfword multiplier array, eight lanes side by side
   pma_half_mul u_half_mul (
      .first_source  (first_source),
      .second_source (second_source),
      .products      (half_prod)
   );

   // Next-state datapath; one process so every written field
   // lands on the same edge
   always_comb begin
      logic [`PMA_DWORD_W-1:0] diff;  // One lane's difference
      diff    = '0;
      state_d = state_q;
      // Strobes last one cycle unless a new operation is taken
      state_d.done    = 1'b0;
      state_d.dest_we = 1'b0;
      if (op_valid) begin
         unique case (op)
            pma_pkg::PMA_OP_NONE: begin
               // Idle slot, nothing written
            end
            pma_pkg::PMA_OP_WORD_MUL_SUB: begin
               // Doubleword lanes: word 0 / word 2 of each source.
               // Operands are assumed sign-extended words; upper
               // word bits are ignored, so any other input gives
               // an undefined but harmless result
               for (int k = 0; k < `PMA_NDWORD; k++) begin
                  diff = msub_lane(word_of(state_q.upper_acc, 2*k),
                                   word_of(state_q.lower_acc, 2*k),
                                   word_of(first_source, 2*k),
                                   word_of(second_source, 2*k));
                  state_d.dest[k*`PMA_DWORD_W +: `PMA_DWORD_W] = diff;
                  state_d.lower_acc[k*`PMA_DWORD_W +: `PMA_DWORD_W] =
                     sext_word(diff[`PMA_WORD_W-1:0]);
                  state_d.upper_acc[k*`PMA_DWORD_W +: `PMA_DWORD_W] =
                     sext_word(diff[`PMA_DWORD_W-1:`PMA_WORD_W]);
               end
               state_d.dest_we = 1'b1;
               state_d.done    = 1'b1;
            end
            pma_pkg::PMA_OP_HALF_MUL: begin
               // Product words interleave between the accumulators
               state_d.lower_acc = {prod_of(half_prod, `PMA_HW_LO2 + 1),
                                    prod_of(half_prod, `PMA_HW_LO2),
                                    prod_of(half_prod, `PMA_HW_LO0 + 1),
                                    prod_of(half_prod, `PMA_HW_LO0)};
               state_d.upper_acc = {prod_of(half_prod, `PMA_HW_UP2 + 1),
                                    prod_of(half_prod, `PMA_HW_UP2),
                                    prod_of(half_prod, `PMA_HW_UP0 + 1),
                                    prod_of(half_prod, `PMA_HW_UP0)};
               // Destination takes the four lowest-lane products
               state_d.dest = half_prod[`PMA_REG_W-1:0];
               state_d.dest_we = 1'b1;
               state_d.done    = 1'b1;
            end
            pma_pkg::PMA_OP_MOVE_UPPER: begin
               // Whole register copy; lower accumulator untouched
               state_d.upper_acc = first_source;
               state_d.done      = 1'b1;
            end
            pma_pkg::PMA_OP_MOVE_LOWER: begin
               // Whole register copy; upper accumulator untouched
               state_d.lower_acc = first_source;
               state_d.done      = 1'b1;
            end
            pma_pkg::PMA_OP_MOVE_INTERLEAVED: begin
               // Only the word-interleaved format is defined; other
               // formats complete without touching the accumulators
               if (fmt == `PMA_FMT_LW) begin
                  for (int k = 0; k < `PMA_NDWORD; k++) begin
                     state_d.lower_acc[2*k*`PMA_WORD_W +: `PMA_WORD_W] =
                        word_of(first_source, 2*k);
                     state_d.upper_acc[2*k*`PMA_WORD_W +: `PMA_WORD_W] =
                        word_of(first_source, 2*k + 1);
                  end
               end
               state_d.done = 1'b1;
            end
            default: begin
               // Unused op codes are dropped with no completion
            end
         endcase
      end
   end

   // State register; accumulators clear at reset
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         state_q.upper_acc <= `PMA_ACC_RST;
         state_q.lower_acc <= `PMA_ACC_RST;
         state_q.dest      <= '0;
         state_q.dest_we   <= 1'b0;
         state_q.done      <= 1'b0;
      end else begin
         state_q <= state_d;
      end
   end

   // Outputs come straight from the state flops
   assign dest_q      = state_q.dest;
   assign dest_we_q   = state_q.dest_we;
   assign done_q      = state_q.done;
   assign upper_acc_q = state_q.upper_acc;
   assign lower_acc_q = state_q.lower_acc;

endmodule
`default_nettype wire

// file: rtl/pma_params.svh
// Constants for the parallel multiply-subtract and accumulator-move datapath.
// Assumes inclusion by bare name from any design file that needs them.
`ifndef PMA_PARAMS_SVH
`define PMA_PARAMS_SVH

`define PMA_REG_W   128        // General register and accumulator width
`define PMA_DWORD_W 64         // Doubleword width
`define PMA_WORD_W  32         // Word width
`define PMA_HALF_W  16         // Halfword width
`define PMA_NWORD   4          // Words per register
`define PMA_NHALF   8          // Halfwords per register
`define PMA_NDWORD  2          // Doublewords per register
`define PMA_OP_W    3          // Width of the operation select
`define PMA_FMT_W   5          // Width of the format selector field
`define PMA_FMT_LW  5'h00      // Format code of the interleaved word move
`define PMA_ACC_RST 128'h0     // Reset value of both accumulators
`define PMA_HW_LO0  0          // Halfword product landing in lower word 0
`define PMA_HW_UP0  2          // Halfword product landing in upper word 0
`define PMA_HW_LO2  4          // Halfword product landing in lower word 2
`define PMA_HW_UP2  6          // Halfword product landing in upper word 2

`endif

// file: rtl/pma_pkg.sv
// Types shared by the multimedia datapath files.
// Assumes pma_params.svh is on the include path.
`include "pma_params.svh"

package pma_pkg;

   // Operation select; code order fixes the values seen on op_code
   typedef enum logic [`PMA_OP_W-1:0] {
      PMA_OP_NONE,
      PMA_OP_WORD_MUL_SUB,
      PMA_OP_HALF_MUL,
      PMA_OP_MOVE_UPPER,
      PMA_OP_MOVE_LOWER,
      PMA_OP_MOVE_INTERLEAVED
   } pma_op_type;

   // Whole state of the datapath top
   typedef struct packed {
      logic [`PMA_REG_W-1:0] upper_acc;  // Upper accumulator
      logic [`PMA_REG_W-1:0] lower_acc;  // Lower accumulator
      logic [`PMA_REG_W-1:0] dest;       // Destination register result
      logic                  dest_we;    // Destination write strobe
      logic                  done;       // Completion strobe
   } pma_state_type;

endpackage

// file: rtl/pma_half_mul.sv
// Eight parallel signed 16x16 multipliers for the halfword multiply.
// Assumes purely combinational use; the caller registers the products.
`timescale 1ns/1ns
`default_nettype none
`include "pma_params.svh"

module pma_half_mul (
   input  wire logic [`PMA_REG_W-1:0]                first_source,
   input  wire logic [`PMA_REG_W-1:0]                second_source,
   output logic      [`PMA_NHALF*`PMA_WORD_W-1:0]    products
);

   // One multiplier per halfword lane; full product fits a word, so no overflow
   for (genvar g = 0; g < `PMA_NHALF; g++) begin : g_lane
      logic signed [`PMA_HALF_W-1:0] a_s;  // Signed lane of first source
      logic signed [`PMA_HALF_W-1:0] b_s;  // Signed lane of second source
      logic signed [`PMA_WORD_W-1:0] p_s;  // Full lane product, sized by its target
      assign a_s = first_source[g*`PMA_HALF_W +: `PMA_HALF_W];
      assign b_s = second_source[g*`PMA_HALF_W +: `PMA_HALF_W];
      // Product sized by the word target, so both lanes sign-extend first
      assign p_s = a_s * b_s;
      assign products[g*`PMA_WORD_W +: `PMA_WORD_W] = p_s;
   end

endmodule
`default_nettype wire

// file: verif/pma_core_asserts.sv
// Checker for the multimedia datapath top, ports only.
// Assumes one clock domain and an active-low async reset.
`timescale 1ns/1ns
`default_nettype none
`include "pma_params.svh"
module pma_core_asserts (
   input wire logic                  core_clk,
   input wire logic                  rstn,
   input wire logic                  op_valid,
   input wire logic [`PMA_OP_W-1:0]  op_code,
   input wire logic [`PMA_FMT_W-1:0] fmt,
   input wire logic [`PMA_REG_W-1:0] first_source,
   input wire logic [`PMA_REG_W-1:0] second_source,
   input wire logic [`PMA_REG_W-1:0] dest_q,
   input wire logic                  dest_we_q,
   input wire logic                  done_q,
   input wire logic [`PMA_REG_W-1:0] upper_acc_q,
   input wire logic [`PMA_REG_W-1:0] lower_acc_q
);
   // Request that completes; idle code 0 and codes 6, 7 leave no trace
   wire logic               tk  = op_valid && (op_code >= 3'h1) && (op_code <= 3'h5);
   // Lane 0 word product and difference, lane 0 and 7 halfword products
   wire logic signed [63:0] wp0 = $signed(first_source[31:0]) * $signed(second_source[31:0]);
   wire logic [63:0]        df0 = {upper_acc_q[31:0], lower_acc_q[31:0]} - wp0;
   wire logic signed [31:0] hp0 = $signed(first_source[15:0]) * $signed(second_source[15:0]);
   wire logic signed [31:0] hp7 = $signed(first_source[127:112]) * $signed(second_source[127:112]);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);
   AST_DONE_TAKEN: assert property (tk |=> done_q) else $error("done missing");
   AST_DONE_ONLY: assert property (!tk |=> !done_q && !dest_we_q) else $error("stray done");
   AST_WE_MUL: assert property (tk && op_code inside {3'h1, 3'h2} |=> dest_we_q) else $error("no write");
   AST_MOVE_UP: assert property (tk && op_code == 3'h3 |=>
      upper_acc_q == $past(first_source) && $stable(lower_acc_q)) else $error("upper move wrong");
   AST_MOVE_LO: assert property (tk && op_code == 3'h4 |=>
      lower_acc_q == $past(first_source) && $stable(upper_acc_q)) else $error("lower move wrong");
   AST_INTERLEAVE: assert property (tk && op_code == 3'h5 && fmt == 5'h00 |=>
      lower_acc_q[31:0] == $past(first_source[31:0]) && upper_acc_q[31:0] == $past(first_source[63:32])
      && lower_acc_q[63:32] == $past(lower_acc_q[63:32])) else $error("interleave wrong");
   AST_HALF_ORDER: assert property (tk && op_code == 3'h2 |=> lower_acc_q[31:0] == $past(hp0)
      && upper_acc_q[127:96] == $past(hp7) && dest_q[31:0] == $past(hp0)) else $error("half mul wrong");
   AST_MSUB: assert property (tk && op_code == 3'h1 |=> dest_q[63:0] == $past(df0)
      && lower_acc_q[63:0] == {{32{dest_q[31]}}, dest_q[31:0]}
      && upper_acc_q[63:0] == {{32{dest_q[63]}}, dest_q[63:32]}) else $error("msub wrong");
   AST_IDLE_HOLD: assert property (!tk |=> $stable(upper_acc_q) && $stable(lower_acc_q)
      && $stable(dest_q)) else $error("state moved");
endmodule
`default_nettype wire

// file: verif/pma_issue_model.sv
// Decoder and register file stand-in feeding the datapath.
// Assumes callers enter its tasks just after a rising edge.
`timescale 1ns/1ns
`default_nettype none
`include "pma_params.svh"
module pma_issue_model (
   output logic                  op_valid,
   output logic [`PMA_OP_W-1:0]  op_code,
   output logic [`PMA_FMT_W-1:0] fmt,
   output logic [`PMA_REG_W-1:0] first_source,
   output logic [`PMA_REG_W-1:0] second_source
);
   // Idle at time zero
   initial begin
      op_valid = 1'b0;
      op_code = 3'h0;
      fmt = 5'h00;
      first_source = '0;
      second_source = '0;
   end
   // One request, driven without waiting and left on until the next issue or idle call
   task automatic issue(input logic [2:0] op, input logic [4:0] f, input logic [127:0] a, input logic [127:0] b);
      op_valid = 1'b1;
      op_code = op;
      fmt = f;
      first_source = a;
      second_source = b;
   endtask
   // Released operands flip so stale values never look valid
   task automatic idle();
      op_valid = 1'b0;
      first_source = ~first_source;
      second_source = ~second_source;
   endtask
endmodule
`default_nettype wire

// file: verif/parallel_mul_sub_and_acc_move_tb.sv
// Self-checking bench for the multimedia datapath.
// Assumes design, checker and issue model compile before it.
`timescale 1ns/1ns
`default_nettype none
`include "pma_params.svh"
module parallel_mul_sub_and_acc_move_tb;
   logic                  core_clk, rstn, op_valid, dest_we_q, done_q;
   logic [`PMA_OP_W-1:0]  op_code;
   logic [`PMA_FMT_W-1:0] fmt;
   logic [`PMA_REG_W-1:0] first_source, second_source, dest_q, upper_acc_q, lower_acc_q;
   logic [`PMA_REG_W-1:0] e_up = '0, e_lo = '0, e_dst = '0;  // Expected state
   logic [31:0]           seed = 32'h07aca021;
   int                    error_cnt = 0;
   int                    checks_done = 0;
   pma_core dut (.core_clk, .rstn, .op_valid, .op_code, .fmt, .first_source, .second_source,
      .dest_q, .dest_we_q, .done_q, .upper_acc_q, .lower_acc_q);
   pma_issue_model pm (.op_valid, .op_code, .fmt, .first_source, .second_source);
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   function automatic logic [31:0] rnd();
      seed = seed[0] ? (seed >> 1) ^ 32'h80200003 : seed >> 1;
      return seed;
   endfunction
   // Reference update; each op sees the state left by the last
   function automatic void predict(input logic [2:0] op, input logic [4:0] f, input logic [127:0] a, b);
      logic signed [63:0] p;
      logic signed [31:0] h;
      logic [63:0]        d;
      case (op)
         3'h1: for (int k = 0; k < 2; k++) begin
            p = $signed(a[64*k+:32]) * $signed(b[64*k+:32]);
            d = {e_up[64*k+:32], e_lo[64*k+:32]} - p;
            e_dst[64*k+:64] = d;
            e_lo[64*k+:64] = {{32{d[31]}}, d[31:0]};
            e_up[64*k+:64] = {{32{d[63]}}, d[63:32]};
         end
         3'h2: for (int i = 0; i < 8; i++) begin
            h = $signed(a[16*i+:16]) * $signed(b[16*i+:16]);
            if (i[1]) e_up[64*i[2]+32*i[0]+:32] = h;
            else e_lo[64*i[2]+32*i[0]+:32] = h;
            if (i < 4) e_dst[32*i+:32] = h;
         end
         3'h3: e_up = a;
         3'h4: e_lo = a;
         3'h5: if (f == 5'h00) begin
            e_lo[31:0] = a[31:0];
            e_up[31:0] = a[63:32];
            e_lo[95:64] = a[95:64];
            e_up[95:64] = a[127:96];
         end
         default: ;
      endcase
   endfunction
   task automatic chk(input logic [127:0] got, input logic [127:0] exp);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // One cycle of traffic, then compare after the answering edge
   task automatic step(input logic v, input logic [2:0] op, input logic [4:0] f, input logic [127:0] a, b);
      if (v) pm.issue(op, f, a, b);
      else pm.idle();
      if (v) predict(op, f, a, b);
      @(posedge core_clk);
      #2;
      chk(done_q, v && op >= 3'h1 && op <= 3'h5);
      chk(dest_we_q, v && op inside {3'h1, 3'h2});
      chk(dest_q, e_dst);
      chk(upper_acc_q, e_up);
      chk(lower_acc_q, e_lo);
   endtask
   task automatic print_verdict();
      if (error_cnt == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      logic [2:0]   op;
      logic [127:0] a, b;
      rstn = 1'b0;
      repeat (8) @(posedge core_clk);
      #2;
      rstn = 1'b1;
      step(1'b0, 3'h0, 5'h00, '0, '0);
      // Corners: full moves, extreme products, refused codes
      step(1'b1, 3'h3, 5'h00, '1, '0);
      step(1'b1, 3'h1, 5'h00, {2{64'hffffffff80000000}}, {2{64'hffffffff80000000}});
      step(1'b1, 3'h2, 5'h00, {8{16'h8000}}, {8{16'h8000}});
      step(1'b1, 3'h5, 5'h01, 128'h44443333222211110, '0);
      step(1'b1, 3'h5, 5'h00, 128'h0123456789abcdeffedcba9876543210, '0);
      step(1'b1, 3'h6, 5'h00, '1, '1);
      step(1'b1, 3'h0, 5'h00, '1, '1);
      step(1'b1, 3'h4, 5'h00, '1, '0);
      repeat (400) begin
         op = 3'(rnd());
         a = {rnd(), rnd(), rnd(), rnd()};
         b = {rnd(), rnd(), rnd(), rnd()};
         if (op == 3'h1) begin
            a = {{32{a[95]}}, a[95:64], {32{a[31]}}, a[31:0]};
            b = {{32{b[95]}}, b[95:64], {32{b[31]}}, b[31:0]};
         end
         step(rnd() % 5 != 0, op, (rnd() % 3 == 0) ? 5'(rnd()) : 5'h00, a, b);
      end
      print_verdict();
   end
   // Hang guard
   initial begin
      #1000000;
      error_cnt++;
      print_verdict();
   end
endmodule
bind pma_core pma_core_asserts u_chk (.core_clk, .rstn, .op_valid, .op_code, .fmt, .first_source,
   .second_source, .dest_q, .dest_we_q, .done_q, .upper_acc_q, .lower_acc_q);
`default_nettype wire
